/* File: sadc_pkg.sv */
// constants, types and state codes for the successive-approximation sequencer
// assumes a single 250 MHz system clock; one state equals one clock cycle
package sadc_pkg;
    localparam int RES_W = 10;
    localparam int NCH = 8;
    localparam int CNT_W = 10;

    typedef logic [NCH-1:0][RES_W-1:0] sadc_res_arr_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DELAY  = 5'b00010,
        ST_SAMPLE = 5'b00100,
        ST_CONV   = 5'b01000,
        ST_STORE  = 5'b10000
    } sadc_state_e;

    // trigger source encodings
    localparam logic [1:0] TRG_OFF = 2'h0;
    localparam logic [1:0] TRG_PULSE_TIMER = 2'h1;
    localparam logic [1:0] TRG_EIGHT_BIT_TIMER = 2'h2;
    localparam logic [1:0] TRG_EXT_PIN = 2'h3;

    // phase lengths in cycles at the fastest clock select; scaled by 2**(3-cks)
    localparam logic [CNT_W-1:0] TD_BASE = 10'h004;
    localparam logic [CNT_W-1:0] SPL_BASE = 10'h010;
    localparam logic [CNT_W-1:0] STEP_BASE = 10'h004;
    localparam logic [CNT_W-1:0] GAP_BASE = 10'h008;
    localparam logic [CNT_W-1:0] SCAN_CONV_BASE = 10'h040;

    // single-mode worst-case conversion times in states per clock select
    localparam logic [CNT_W-1:0] SINGLE_MAX_00 = 10'h212;
    localparam logic [CNT_W-1:0] SINGLE_MAX_01 = 10'h10A;
    localparam logic [CNT_W-1:0] SINGLE_MAX_10 = 10'h086;
    localparam logic [CNT_W-1:0] SINGLE_MAX_11 = 10'h044;

    // values after reset; SAR_MSB and MSB_IDX are loaded during sampling
    localparam logic MSTOP_RST = 1'b1;
    localparam logic [1:0] CKS_RST = 2'h0;
    localparam logic [1:0] TRG_RST = 2'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
    localparam logic [3:0] MSB_IDX = 4'h9;
endpackage

/* File: sadc_sequencer.sv */
// sequencer for a 10-bit successive-approximation converter: control bits, trigger
// selection, single and scan sequencing, timing, result registers and completion flag.
// assumes an analog comparator and sample-and-hold outside; control bits arrive as
// write strobes from the local register decoder on the same clock.
// Function
// - 10-bit results, single or scan mode only
// - single mode starts when start bit sets
// - single result stored to its channel
// - end sets done flag, irq if enabled
// - single start bit cleared by hardware at end
// - clearing start bit aborts to idle
// - scan groups of up to four or eight channels, ending at the selected channel
// - group first channel: four or zero
// - each scan result stored when channel finishes
// - group end flags then restarts first channel
// - scan never clears start bit itself
// - restart after stop begins at first channel
// - start delay, then sample, then approximation
// - start delay and 127/63/31/15-state sampling window
// - single conversion within 530/266/134/68 states
// - later scan conversions fixed 512/256/128/64 states
// - pin falling edge sets start bit
// - pin start behaves like software start
// - done irq can drive transfer controllers
// - module held stopped after reset
// - trigger select decode of off and three sources
// - channel select picks input or group
// - done flag cleared only by writing 0
`timescale 1ns/10ps
module sadc_sequencer
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic mstop_wr_i,
    input wire logic mstop_val_i,
    input wire logic ctrl_wr_i,
    input wire logic wr_start_i,
    input wire logic wr_done_flag_i,
    input wire logic wr_irq_en_i,
    input wire logic [3:0] wr_chan_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] wr_trig_sel_i,
    input wire logic wr_scan_en_i,
    input wire logic wr_scan_size_i,
    input wire logic [1:0] wr_clk_sel_i,
    input wire logic pulse_timer_trig_i,
    input wire logic eight_bit_timer_trig_i,
    input wire logic ext_trigger_pin_n_i,
    input wire logic cmp_i,
    output logic module_stop_o,
    output logic start_bit_o,
    output logic done_flag_o,
    output logic irq_en_o,
    output logic [3:0] chan_o,
    output logic [1:0] trig_sel_o,
    output logic scan_en_o,
    output logic scan_size_o,
    output logic [1:0] clk_sel_o,
    output logic conversion_done_irq_o,
    output logic xfer_req_o,
    output logic sample_o,
    output logic [2:0] ain_sel_o,
    output logic [sadc_pkg::RES_W-1:0] dac_code_o,
    output sadc_pkg::sadc_res_arr_t results_o
);
    import sadc_pkg::*;

    sadc_state_e state_q;
    sadc_state_e state_d;
    logic mstop_q;
    logic start_q;
    logic done_q;
    logic irq_en_q;
    logic [3:0] chan_q;
    logic [1:0] trg_q;
    logic scan_en_q;
    logic scan_size_q;
    logic [1:0] cks_q;
    logic xfer_q;
    logic [CNT_W-1:0] cnt_q;
    logic [3:0] bit_q;
    logic [RES_W-1:0] sar_q;
    logic [2:0] cur_q;
    sadc_res_arr_t res_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic cmp_s1_q;
    logic cmp_s2_q;
    logic [1:0] sh;
    logic run;
    logic ctrl_ok;
    logic cfg_ok;
    logic pin_fall;
    logic trig_set;
    logic cnt_zero;
    logic [2:0] first_ch;
    logic [2:0] last_ch;
    logic group_end;
    logic done_set;

    function automatic logic [CNT_W-1:0] cyc(input logic [CNT_W-1:0] base, input logic [1:0] s);
        cyc = base << s;
    endfunction

    // registers stay frozen until the module is released from stop
    assign ctrl_ok = ctrl_wr_i & ~mstop_q;
    assign cfg_ok = cfg_wr_i & ~mstop_q;
    assign sh = ~cks_q;
    assign run = start_q & ~mstop_q;
    assign cnt_zero = (cnt_q == '0);
    assign pin_fall = pin_s3_q & ~pin_s2_q;

    always_comb
    begin
        case (trg_q)
            TRG_PULSE_TIMER: trig_set = pulse_timer_trig_i;
            TRG_EIGHT_BIT_TIMER: trig_set = eight_bit_timer_trig_i;
            TRG_EXT_PIN: trig_set = pin_fall;
            default: trig_set = 1'b0;
        endcase
    end

    // the top select bit is a prohibited setting and is ignored
    assign last_ch = chan_q[2:0];
    always_comb
    begin
        if (!scan_en_q)
            first_ch = chan_q[2:0];
        else if (scan_size_q)
            first_ch = 3'h0;
        else
            first_ch = {chan_q[2], 2'h0};
    end
    assign group_end = ~scan_en_q | (cur_q == last_ch);
    assign done_set = (state_q == ST_STORE) & group_end;

    // module stop control
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            mstop_q <= MSTOP_RST;
        else if (mstop_wr_i)
            mstop_q <= mstop_val_i;
    end

    // configuration; mode and clock select are used live, software changes them stopped
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            trg_q <= TRG_RST;
            scan_en_q <= 1'b0;
            scan_size_q <= 1'b0;
            cks_q <= CKS_RST;
            irq_en_q <= 1'b0;
            chan_q <= CHAN_RST;
        end
        else
        begin
            if (cfg_ok)
            begin
                trg_q <= wr_trig_sel_i;
                scan_en_q <= wr_scan_en_i;
                scan_size_q <= wr_scan_size_i;
                cks_q <= wr_clk_sel_i;
            end
            if (ctrl_ok)
            begin
                irq_en_q <= wr_irq_en_i;
                chan_q <= wr_chan_i;
            end
        end
    end

    // start bit: a trigger in the cycle of a clear still sets it
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            start_q <= 1'b0;
        else if (mstop_q)
            start_q <= 1'b0;
        else if (trig_set)
            start_q <= 1'b1;
        else if (ctrl_ok)
            start_q <= wr_start_i;
        else if (state_q == ST_STORE && !scan_en_q)
            start_q <= 1'b0;
    end

    // completion flag: set wins over the write of zero, a write of one is ignored
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            done_q <= 1'b0;
            xfer_q <= 1'b0;
        end
        else
        begin
            if (done_set)
                done_q <= 1'b1;
            else if (ctrl_ok && !wr_done_flag_i)
                done_q <= 1'b0;
            xfer_q <= done_set & irq_en_q;
        end
    end

    // pin and comparator synchronisers; edge detect reads only later stages
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= ext_trigger_pin_n_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            cmp_s1_q <= cmp_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (run) state_d = ST_DELAY;
            ST_DELAY: if (cnt_zero) state_d = ST_SAMPLE;
            ST_SAMPLE: if (cnt_zero) state_d = ST_CONV;
            ST_CONV: if (cnt_zero && bit_q == '0) state_d = ST_STORE;
            ST_STORE: state_d = scan_en_q ? ST_DELAY : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
        if (!run)
            state_d = ST_IDLE;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // phase timer; scan gap plus store makes later conversions exactly 64 units
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (state_q == ST_IDLE)
            cnt_q <= cyc(TD_BASE, sh) - 10'h001;
        else if (state_q == ST_STORE)
            cnt_q <= cyc(GAP_BASE, sh) - 10'h001;
        else if (!cnt_zero)
            cnt_q <= cnt_q - 10'h001;
        else if (state_q == ST_DELAY)
            cnt_q <= cyc(SPL_BASE, sh) - 10'h002;
        else
            cnt_q <= cyc(STEP_BASE, sh) - 10'h001;
    end

    // successive approximation, msb first, comparator high keeps the trial bit
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            sar_q <= '0;
            bit_q <= '0;
        end
        else if (state_q == ST_SAMPLE)
        begin
            sar_q <= SAR_MSB;
            bit_q <= MSB_IDX;
        end
        else if (state_q == ST_CONV && cnt_zero)
        begin
            sar_q[bit_q] <= cmp_s2_q;
            if (bit_q != '0)
            begin
                sar_q[bit_q-4'h1] <= 1'b1;
                bit_q <= bit_q - 4'h1;
            end
        end
    end

    // channel pointer: loaded from the group head on every start
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            cur_q <= '0;
        else if (state_q == ST_IDLE)
            cur_q <= first_ch;
        else if (state_q == ST_STORE)
            cur_q <= group_end ? first_ch : cur_q + 3'h1;
    end

    for (genvar g = 0; g < NCH; g++)
    begin : g_res
        always_ff @(posedge core_clk_i)
        begin
            if (!rst_n_i)
                res_q[g] <= RES_RST;
            else if (state_q == ST_STORE && cur_q == 3'(g))
                res_q[g] <= sar_q;
        end
    end

    assign module_stop_o = mstop_q;
    assign start_bit_o = start_q;
    assign done_flag_o = done_q;
    assign irq_en_o = irq_en_q;
    assign chan_o = chan_q;
    assign trig_sel_o = trg_q;
    assign scan_en_o = scan_en_q;
    assign scan_size_o = scan_size_q;
    assign clk_sel_o = cks_q;
    assign conversion_done_irq_o = done_q & irq_en_q;
    assign xfer_req_o = xfer_q;
    assign sample_o = (state_q == ST_SAMPLE);
    assign ain_sel_o = cur_q;
    assign dac_code_o = sar_q;
    assign results_o = res_q;

    // checking helpers: cycles since the last store or start, sampling length
    logic [CNT_W-1:0] per_q;
    logic [CNT_W-1:0] spl_q;
    logic prev_store_q;
    logic [CNT_W-1:0] single_max;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || state_q == ST_IDLE || state_q == ST_STORE)
            per_q <= 10'h001;
        else
            per_q <= per_q + 10'h001;
        if (!rst_n_i || state_q != ST_SAMPLE)
            spl_q <= '0;
        else
            spl_q <= spl_q + 10'h001;
        if (!rst_n_i || state_q == ST_IDLE)
            prev_store_q <= 1'b0;
        else if (state_q == ST_STORE)
            prev_store_q <= 1'b1;
    end
    always_comb
    begin
        case (cks_q)
            2'h0: single_max = SINGLE_MAX_00;
            2'h1: single_max = SINGLE_MAX_01;
            2'h2: single_max = SINGLE_MAX_10;
            default: single_max = SINGLE_MAX_11;
        endcase
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pin_start;
        trg_q == TRG_EXT_PIN && pin_fall && !mstop_q;
    endsequence
    sequence s_single_end;
        state_q == ST_STORE && !scan_en_q && !trig_set && !ctrl_ok && !mstop_wr_i;
    endsequence

    a_pin_sets_start: assert property (s_pin_start |=> start_q ##1 state_q == ST_DELAY)
        else $error("pin falling edge did not start conversion");
    a_single_clears: assert property (s_single_end |=> !start_q && state_q == ST_IDLE)
        else $error("single conversion end did not clear start bit");
    a_scan_holds: assert property (scan_en_q && start_q && !ctrl_ok && !mstop_wr_i |=> start_q)
        else $error("scan mode cleared start bit");
    a_abort_idle: assert property (state_q != ST_IDLE && !start_q |-> state_d == ST_IDLE ##1 state_q == ST_IDLE)
        else $error("cleared start bit did not abort");
    a_done_flag_set: assert property (done_set |=> done_q && (xfer_req_o == $past(irq_en_q)))
        else $error("completion did not set flag or request");
    a_flag_write_one: assert property (done_q && ctrl_ok && wr_done_flag_i |=> done_q)
        else $error("writing one changed the done flag");
    a_result_store: assert property (state_q == ST_STORE |=> res_q[$past(cur_q)] == $past(sar_q))
        else $error("result not stored to converted channel");
    a_group_wrap: assert property (state_q == ST_STORE && scan_en_q && group_end && run |=> cur_q == $past(first_ch))
        else $error("scan did not wrap to first channel");
    a_restart_head: assert property (state_q == ST_IDLE && run |=> state_q == ST_DELAY && cur_q == $past(first_ch))
        else $error("start did not begin at group head");
    a_sample_window: assert property ($fell(sample_o) && state_q == ST_CONV |-> spl_q == cyc(SPL_BASE, sh) - 10'h001)
        else $error("sampling window length wrong");
    a_single_time: assert property (state_q == ST_STORE && !prev_store_q |-> per_q <= single_max)
        else $error("first conversion too long");
    a_scan_period: assert property (state_q == ST_STORE && prev_store_q |-> per_q == cyc(SCAN_CONV_BASE, sh))
        else $error("scan conversion period wrong");
endmodule

/* File: sadc_analog_model.sv */
// analog side stand-in: one fixed level per input channel and a comparator
// assumes ain_sel_i stays steady while sample_i is high
`timescale 1ns/10ps
module sadc_analog_model
(
    input wire logic core_clk_i,
    input wire logic sample_i,
    input wire logic [2:0] ain_sel_i,
    input wire logic [9:0] dac_code_i,
    output logic cmp_o
);
    logic [9:0] held_q;
    initial held_q = 10'h000;
    // level frozen once sampling ends, so a late channel change shows up as a wrong code
    always @(posedge core_clk_i)
    begin
        if (sample_i)
        begin
            held_q <= 10'h05A + 10'h067 * {7'h00, ain_sel_i};
        end
    end
    assign cmp_o = (held_q >= dac_code_i);
endmodule

/* File: test_sadc_sequencer.sv */
// self-checking bench for the converter sequencer
// assumes sadc_analog_model answers the comparator; inputs change on falling edges
`timescale 1ns/10ps
module test_sadc_sequencer;
    import sadc_pkg::*;
    logic core_clk_i, rst_n_i, mstop_wr_i, mstop_val_i, ctrl_wr_i, wr_start_i, wr_done_flag_i, wr_irq_en_i;
    logic cfg_wr_i, wr_scan_en_i, wr_scan_size_i, pulse_timer_trig_i, eight_bit_timer_trig_i;
    logic ext_trigger_pin_n_i, cmp_i, module_stop_o, start_bit_o, done_flag_o, irq_en_o, scan_en_o;
    logic scan_size_o, conversion_done_irq_o, xfer_req_o, sample_o;
    logic [3:0] wr_chan_i, chan_o;
    logic [1:0] wr_trig_sel_i, wr_clk_sel_i, trig_sel_o, clk_sel_o;
    logic [2:0] ain_sel_o;
    logic [RES_W-1:0] dac_code_o;
    sadc_res_arr_t results_o;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic smp_q = 1'b0;
    int sq_ch[$];
    int sq_t[$];

    sadc_sequencer sadc_sequencer_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mstop_wr_i(mstop_wr_i),
        .mstop_val_i(mstop_val_i), .ctrl_wr_i(ctrl_wr_i), .wr_start_i(wr_start_i),
        .wr_done_flag_i(wr_done_flag_i), .wr_irq_en_i(wr_irq_en_i), .wr_chan_i(wr_chan_i),
        .cfg_wr_i(cfg_wr_i), .wr_trig_sel_i(wr_trig_sel_i), .wr_scan_en_i(wr_scan_en_i),
        .wr_scan_size_i(wr_scan_size_i), .wr_clk_sel_i(wr_clk_sel_i), .pulse_timer_trig_i(pulse_timer_trig_i),
        .eight_bit_timer_trig_i(eight_bit_timer_trig_i), .ext_trigger_pin_n_i(ext_trigger_pin_n_i),
        .cmp_i(cmp_i), .module_stop_o(module_stop_o), .start_bit_o(start_bit_o), .done_flag_o(done_flag_o),
        .irq_en_o(irq_en_o), .chan_o(chan_o), .trig_sel_o(trig_sel_o), .scan_en_o(scan_en_o),
        .scan_size_o(scan_size_o), .clk_sel_o(clk_sel_o), .conversion_done_irq_o(conversion_done_irq_o),
        .xfer_req_o(xfer_req_o), .sample_o(sample_o), .ain_sel_o(ain_sel_o), .dac_code_o(dac_code_o),
        .results_o(results_o));

    sadc_analog_model sadc_analog_model_i (.core_clk_i(core_clk_i), .sample_i(sample_o),
        .ain_sel_i(ain_sel_o), .dac_code_i(dac_code_o), .cmp_o(cmp_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // start of every sampling window, with the channel and the cycle it began on
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        smp_q <= sample_o;
        if (sample_o === 1'b1 && smp_q === 1'b0)
        begin
            sq_ch.push_back(int'(ain_sel_o));
            sq_t.push_back(cyc);
        end
    end

    function automatic logic [9:0] ev(input int c);
        return 10'(10'h05A + 10'h067 * c);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (err_total == 0 && check_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic wr_ctrl(input logic st, input logic fl, input logic ie, input logic [3:0] ch);
        @(negedge core_clk_i);
        ctrl_wr_i = 1'b1;
        wr_start_i = st;
        wr_done_flag_i = fl;
        wr_irq_en_i = ie;
        wr_chan_i = ch;
        @(negedge core_clk_i);
        ctrl_wr_i = 1'b0;
    endtask

    task automatic wr_cfg(input logic [1:0] tr, input logic se, input logic ss, input logic [1:0] ck);
        @(negedge core_clk_i);
        cfg_wr_i = 1'b1;
        wr_trig_sel_i = tr;
        wr_scan_en_i = se;
        wr_scan_size_i = ss;
        wr_clk_sel_i = ck;
        @(negedge core_clk_i);
        cfg_wr_i = 1'b0;
    endtask

    task automatic wait_done();
        for (int i = 0; i < 1000 && done_flag_o !== 1'b1; i++)
        begin
            @(negedge core_clk_i);
        end
    endtask

    // scan of group f..l: one full pass plus two channels, stop mid-group, then restart
    task automatic scan(input logic sz, input logic [3:0] ch, input int f, input int l);
        int n;
        n = l - f + 1;
        wr_ctrl(1'b0, 1'b0, 1'b0, ch);
        wr_cfg(2'h0, 1'b1, sz, 2'h3);
        sq_ch.delete();
        sq_t.delete();
        wr_ctrl(1'b1, 1'b1, 1'b0, ch);
        for (int i = 0; i < 3000 && sq_ch.size() < n + 2; i++)
        begin
            @(negedge core_clk_i);
        end
        chk(start_bit_o, 1'b1);
        chk(done_flag_o, 1'b1);
        chk(conversion_done_irq_o, 1'b0);
        wr_ctrl(1'b0, 1'b1, 1'b0, ch);
        tick(4);
        chk(sample_o, 1'b0);
        chk(16'(sq_ch.size()), 16'(n + 2));
        for (int i = 0; i < n + 2 && i < sq_ch.size(); i++)
        begin
            chk(16'(sq_ch[i]), 16'(f + i % n));
            if (i > 0) chk(16'(sq_t[i] - sq_t[i - 1]), 16'd64);
        end
        for (int c = f; c <= l; c++) chk(results_o[c], ev(c));
        sq_ch.delete();
        sq_t.delete();
        wr_ctrl(1'b1, 1'b1, 1'b0, ch);
        for (int i = 0; i < 100 && sq_ch.size() == 0; i++) @(negedge core_clk_i);
        chk(16'(sq_ch.size() > 0 ? sq_ch[0] : 99), 16'(f));
        wr_ctrl(1'b0, 1'b0, 1'b0, ch);
    endtask

    initial
    begin
        int nst;
        int nsp;
        int dly;
        int lim[4] = '{530, 266, 134, 68};
        {rst_n_i, mstop_wr_i, mstop_val_i, ctrl_wr_i, wr_start_i, wr_done_flag_i, wr_irq_en_i} = 7'h00;
        {cfg_wr_i, wr_scan_en_i, wr_scan_size_i, pulse_timer_trig_i, eight_bit_timer_trig_i} = 5'h00;
        ext_trigger_pin_n_i = 1'b1;
        wr_chan_i = 4'h0;
        wr_trig_sel_i = 2'h0;
        wr_clk_sel_i = 2'h0;
        tick(2);
        rst_n_i = 1'b1;
        chk(module_stop_o, 1'b1);
        wr_ctrl(1'b1, 1'b1, 1'b1, 4'h4);
        chk(start_bit_o, 1'b0);
        mstop_wr_i = 1'b1;
        @(negedge core_clk_i);
        mstop_wr_i = 1'b0;
        chk(module_stop_o, 1'b0);
        // every clock select: window, total time and stored code; delay at clock select 0 only
        for (int k = 0; k < 4; k++)
        begin
            wr_cfg(2'h0, 1'b0, 1'b0, 2'(k));
            wr_ctrl(1'b1, 1'b1, 1'b1, 4'(k + 4));
            nst = 0;
            nsp = 0;
            dly = 0;
            for (int i = 0; i < 1000 && done_flag_o !== 1'b1; i++)
            begin
                @(posedge core_clk_i);
                #1;
                nst += int'(start_bit_o === 1'b1);
                nsp += int'(sample_o === 1'b1);
                if (nsp == 0) dly = nst;
            end
            if (k == 0) chk(dly >= 18 && dly <= 33, 1'b1);
            chk(16'(nsp), 16'((16 << (3 - k)) - 1));
            chk(nst + 1 <= lim[k], 1'b1);
            chk(start_bit_o, 1'b0);
            chk(results_o[k + 4], ev(k + 4));
            chk(conversion_done_irq_o, 1'b1);
            chk(xfer_req_o, 1'b1);
            tick(2);
            chk(xfer_req_o, 1'b0);
            wr_ctrl(1'b0, 1'b1, 1'b1, 4'(k + 4));
            chk(done_flag_o, 1'b1);
            wr_ctrl(1'b0, 1'b0, 1'b1, 4'(k + 4));
            chk(done_flag_o, 1'b0);
        end
        wr_ctrl(1'b1, 1'b1, 1'b0, 4'h3);
        tick(20);
        wr_ctrl(1'b0, 1'b1, 1'b0, 4'h3);
        tick(100);
        chk(done_flag_o, 1'b0);
        chk(sample_o, 1'b0);
        chk(results_o[3], 10'h000);
        scan(1'b0, 4'h7, 4, 7);
        scan(1'b1, 4'h2, 0, 2);
        // each trigger select against each source fired alone
        // channel 3 holds zero from the abort, so a triggered result is visible
        wr_ctrl(1'b0, 1'b0, 1'b0, 4'h3);
        for (int t = 0; t < 4; t++)
        begin
            for (int s = 1; s < 4; s++)
            begin
                wr_cfg(2'(t), 1'b0, 1'b0, 2'h3);
                @(negedge core_clk_i);
                pulse_timer_trig_i = (s == 1);
                eight_bit_timer_trig_i = (s == 2);
                ext_trigger_pin_n_i = (s != 3);
                @(negedge core_clk_i);
                pulse_timer_trig_i = 1'b0;
                eight_bit_timer_trig_i = 1'b0;
                tick(6);
                ext_trigger_pin_n_i = 1'b1;
                chk(start_bit_o, 1'(t == s));
                if (t == s)
                begin
                    wait_done();
                    chk(results_o[3], ev(3));
                end
                wr_ctrl(1'b0, 1'b0, 1'b0, 4'h3);
            end
        end
        results();
    end

    initial
    begin
        #(20000 * 4);
        err_total++;
        results();
    end
endmodule
